// file: dv/tpc_monitor.sv
// concurrent checks on the tpc_top ports
// assumes one pclk domain and the asynchronous active low presetn
`timescale 1ns/1ns
module tpc_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        step_up_in,
	input wire logic        step_dn_in,
	input wire logic        hold_n,
	input wire logic        resolution_select_a,
	input wire logic        resolution_select_b,
	input wire logic [15:0] position,
	input wire logic        busy,
	input wire logic        carry,
	input wire logic        dir
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// pulse length counters
	// ----------------------------------------------------------------
	logic [7:0] busy_run_r;
	logic [7:0] carry_run_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_run_r  <= 8'h00;
			carry_run_r <= 8'h00;
		end else begin
			busy_run_r  <= busy ? busy_run_r + 8'h01 : 8'h00;
			carry_run_r <= carry ? carry_run_r + 8'h01 : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_res10_idle;
		(!resolution_select_a && !resolution_select_b && hold_n && !busy) [*8];
	endsequence
	property p_step_busy;
		($rose(step_up_in) && !step_dn_in) |-> ##[3:6] busy;
	endproperty
	property p_busy_width;
		$fell(busy) |-> busy_run_r >= 8'(tpc_pkg::BUSY_CYC);
	endproperty
	property p_carry_width;
		$fell(carry) |-> carry_run_r >= 8'(tpc_pkg::CARRY_CYC);
	endproperty
	property p_dir_first;
		$rose(carry) |-> $stable(dir) && busy;
	endproperty
	property p_carry_wrap;
		($rose(carry) && hold_n && $past(hold_n, 8)) |-> (position[15:6] == 10'h000 || &position[15:6]);
	endproperty
	property p_dir_moves;
		$changed(dir) |-> busy;
	endproperty
	property p_pos_busy;
		$changed(position) |-> busy;
	endproperty
	property p_hold_freeze;
		(!hold_n) [*6] |-> $stable(position);
	endproperty
	property p_hold_release;
		$rose(hold_n) |-> ##[2:7] busy;
	endproperty
	property p_res10_lsb;
		s_res10_idle ##1 busy |-> position[5:0] == 6'h00;
	endproperty
	property p_apb_wait;
		(psel && penable && !pready) |-> ##1 pready;
	endproperty

	a_step_busy: assert property (p_step_busy) else $error("no busy after step");
	a_busy_width: assert property (p_busy_width) else $error("busy pulse too short");
	a_carry_width: assert property (p_carry_width) else $error("carry pulse too short");
	a_dir_first: assert property (p_dir_first) else $error("dir moved with carry");
	a_carry_wrap: assert property (p_carry_wrap) else $error("carry without wrap");
	a_dir_moves: assert property (p_dir_moves) else $error("dir moved without step");
	a_pos_busy: assert property (p_pos_busy) else $error("position moved while not busy");
	a_hold_freeze: assert property (p_hold_freeze) else $error("position moved under hold");
	a_hold_release: assert property (p_hold_release) else $error("no busy on hold release");
	a_res10_lsb: assert property (p_res10_lsb) else $error("low bits set at 10 bits");
	a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");
endmodule

bind tpc_top tpc_monitor u_tpc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .step_up_in(step_up_in), .step_dn_in(step_dn_in), .hold_n(hold_n),
	.resolution_select_a(resolution_select_a), .resolution_select_b(resolution_select_b),
	.position(position), .busy(busy), .carry(carry), .dir(dir));

// file: dv/tpc_rev_model.sv
// external revolution counter and position reader on the output pins
// assumes carry, dir, busy and position come from tpc_top on pclk
`timescale 1ns/1ns
module tpc_rev_model (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        carry,
	input wire logic        dir,
	input wire logic        busy,
	input wire logic [15:0] position,
	output logic     [15:0] revs,
	output logic     [15:0] pos_seen
);
	logic carry_q;
	logic busy_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_q  <= 1'b0;
			busy_q   <= 1'b0;
			revs     <= 16'h0000;
			pos_seen <= 16'h0000;
		end else begin
			carry_q <= carry;
			busy_q  <= busy;
			// count revolutions on the carry edge, direction already valid
			if (carry && !carry_q) begin
				revs <= dir ? revs - 16'h0001 : revs + 16'h0001;
			end
			// read position only once busy has dropped
			if (busy_q && !busy) begin
				pos_seen <= position;
			end
		end
	end
endmodule

// file: dv/tracking_position_counter_out_tb_top.sv
// self-checking bench for tpc_top: apb tasks, step pin driver, revolution model
// assumes the hw files, the monitor and the model are compiled first
`timescale 1ns/1ns
module tracking_position_counter_out_tb_top;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        step_up_in, step_dn_in, hold_n, resolution_select_a, resolution_select_b;
	logic [15:0] position, revs, pos_seen, stp, msk;
	logic        busy, carry, dir, irq, er;
	logic        busy_q = 1'b0;
	int          nb = 0;
	int          nb0;
	int          n_mismatch = 0;
	int          n_checks = 0;

	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		busy_q <= busy;
		if (busy === 1'b1 && busy_q === 1'b0) nb <= nb + 1;
	end

	tpc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.step_up_in(step_up_in), .step_dn_in(step_dn_in), .hold_n(hold_n),
		.resolution_select_a(resolution_select_a), .resolution_select_b(resolution_select_b),
		.position(position), .busy(busy), .carry(carry), .dir(dir), .irq(irq));
	tpc_rev_model u_model (.pclk(pclk), .presetn(presetn), .carry(carry), .dir(dir), .busy(busy),
		.position(position), .revs(revs), .pos_seen(pos_seen));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (i >= 20) begin
			chk("apb answer", 32'h0000_0000, 32'h0000_0001);
			end_of_test();
		end
	endtask

	// one lsb step on a pin, then wait until busy and carry are low
	task automatic step(input logic up);
		int i;
		@(posedge pclk);
		if (up) step_up_in <= 1'b1;
		else step_dn_in <= 1'b1;
		repeat (4) @(posedge pclk);
		step_up_in <= 1'b0;
		step_dn_in <= 1'b0;
		repeat (8) @(posedge pclk);
		for (i = 0; i < 200 && (busy !== 1'b0 || carry !== 1'b0); i++) @(posedge pclk);
		if (i >= 200) begin
			chk("idle wait", 32'h0000_0000, 32'h0000_0001);
			end_of_test();
		end
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, step_up_in, step_dn_in} = 6'h00;
		{resolution_select_a, resolution_select_b, hold_n} = 3'h1;
		paddr  = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, tpc_pkg::ADDR_POS, 32'h0000_0000);
		chk("pos reset", rd, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped err", {31'h0000_0000, er}, 32'h0000_0001);
		chk("no busy after reset", nb, 32'h0000_0000);
		apb(1'b1, tpc_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
		for (int r = 0; r < 4; r++) begin
			{resolution_select_b, resolution_select_a} <= 2'(r);
			repeat (10) @(posedge pclk);
			stp = 16'h0001 << (6 - 2 * r);
			msk = ~(stp - 16'h0001);
			nb0 = nb;
			step(1'b0);
			apb(1'b0, tpc_pkg::ADDR_POS, 32'h0000_0000);
			chk("pos word", rd, {12'h000, 2'(r), 1'b0, 1'b1, msk});
			chk("position pins", {16'h0000, position}, {16'h0000, msk});
			chk("reader position", {16'h0000, pos_seen}, {16'h0000, msk});
			chk("revs down", {16'h0000, revs}, 32'h0000_ffff);
			chk("carry irq", {31'h0000_0000, irq}, 32'h0000_0001);
			apb(1'b0, tpc_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
			chk("irq status", rd, 32'h0000_0007);
			apb(1'b1, tpc_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
			repeat (3) @(posedge pclk);
			chk("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
			repeat (3) step(1'b1);
			chk("pos up", {16'h0000, position}, {16'h0000, stp << 1});
			chk("dir up", {31'h0000_0000, dir}, 32'h0000_0000);
			chk("busy count", nb, nb0 + 4);
			apb(1'b0, tpc_pkg::ADDR_REVS, 32'h0000_0000);
			chk("revs reg", {16'h0000, rd[15:0]}, 32'h0000_0000);
			repeat (2) step(1'b0);
			chk("dir down", {31'h0000_0000, dir}, 32'h0000_0001);
			$display("test resolution %0d done", r);
		end
		step(1'b1);
		hold_n <= 1'b0;
		repeat (6) @(posedge pclk);
		repeat (2) step(1'b0);
		chk("held pos", {16'h0000, position}, 32'h0000_0001);
		chk("held dir", {31'h0000_0000, dir}, 32'h0000_0001);
		chk("held carry", {16'h0000, revs}, 32'h0000_ffff);
		nb0 = nb;
		hold_n <= 1'b1;
		repeat (12) @(posedge pclk);
		chk("release busy", nb, nb0 + 1);
		chk("release pos", {16'h0000, position}, 32'h0000_ffff);
		step(1'b0);
		apb(1'b1, tpc_pkg::ADDR_CTRL, 32'h0000_0001);
		step(1'b1);
		chk("soft hold pos", {16'h0000, position}, 32'h0000_fffe);
		apb(1'b1, tpc_pkg::ADDR_CTRL, 32'h0000_0000);
		repeat (12) @(posedge pclk);
		chk("soft release pos", {16'h0000, position}, 32'h0000_ffff);
		$display("test hold done");
		apb(1'b1, tpc_pkg::ADDR_POS, 32'h0000_1234);
		apb(1'b0, tpc_pkg::ADDR_POS, 32'h0000_0000);
		chk("pos read only", {16'h0000, rd[15:0]}, 32'h0000_ffff);
		apb(1'b1, tpc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		apb(1'b1, tpc_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
		step(1'b1);
		chk("masked irq", {31'h0000_0000, irq}, 32'h0000_0000);
		apb(1'b1, tpc_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk("step irq", {31'h0000_0000, irq}, 32'h0000_0001);
		apb(1'b0, tpc_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
		chk("step status", {31'h0000_0000, rd[0]}, 32'h0000_0001);
		apb(1'b1, tpc_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk("irq low", {31'h0000_0000, irq}, 32'h0000_0000);
		$display("test registers done");
		end_of_test();
	end
endmodule

// file: hw/tpc_cnt_if.sv
// bundle between the control logic and the up/down position counter
// assumes both ends share pclk
`timescale 1ns/1ns
interface tpc_cnt_if;
	logic                     step_up;
	logic                     step_dn;
	logic [tpc_pkg::POS_W-1:0] mask;
	logic [tpc_pkg::POS_W-1:0] inc;
	logic [tpc_pkg::POS_W-1:0] count;
	logic                     dir;
	logic                     stepped;
	logic                     wrapped;

	modport ctrl (
		output step_up,
		output step_dn,
		output mask,
		output inc,
		input  count,
		input  dir,
		input  stepped,
		input  wrapped
	);

	modport cnt (
		input  step_up,
		input  step_dn,
		input  mask,
		input  inc,
		output count,
		output dir,
		output stepped,
		output wrapped
	);
endinterface

// file: hw/tpc_counter.sv
// up/down position counter, msb aligned, wrapping at the selected resolution
// assumes step_up and step_dn are single-cycle strobes on pclk
`timescale 1ns/1ns
module tpc_counter (
	input  wire logic pclk,
	input  wire logic presetn,
	tpc_cnt_if.cnt    cif
);
	logic [tpc_pkg::POS_W-1:0] count_r;
	logic [tpc_pkg::POS_W-1:0] count_nxt;
	logic                      dir_r;
	logic                      stepped_r;
	logic                      wrapped_r;
	logic                      move;
	logic                      wrap;

	assign move = cif.step_up ^ cif.step_dn;
	// major carry: all ones up to zero, or zero down to all ones
	assign wrap = move & (cif.step_up ? ((count_r & cif.mask) == cif.mask)
	                                  : ((count_r & cif.mask) == '0));    // [R7]

	always_comb begin
		count_nxt = count_r;
		if (cif.step_up && !cif.step_dn) begin
			count_nxt = (count_r + cif.inc) & cif.mask;                // [R3] [R16]
		end else if (cif.step_dn && !cif.step_up) begin
			count_nxt = (count_r - cif.inc) & cif.mask;                // [R3] [R16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= tpc_pkg::POS_RST;
		end else begin
			count_r <= count_nxt & cif.mask;                           // [R14]
		end
	end

	// direction latch changes only on a real step the other way
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_r <= 1'b0;
		end else if (move) begin
			dir_r <= cif.step_dn;                                      // [R9]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stepped_r <= 1'b0;
			wrapped_r <= 1'b0;
		end else begin
			stepped_r <= move;
			wrapped_r <= wrap;
		end
	end

	assign cif.count   = count_r;
	assign cif.dir     = dir_r;
	assign cif.stepped = stepped_r;
	assign cif.wrapped = wrapped_r;
endmodule

// file: hw/tpc_pkg.sv
// constants shared by the tracking position counter block
// assumes a single 100 MHz clock domain and a 32-bit apb register bus
package tpc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned BUSY_NS       = 200;
	localparam int unsigned CARRY_NS      = 300;
	localparam int unsigned BUSY_CYC      = (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CARRY_CYC     = (CARRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMR_W         = 6;

	// ----------------------------------------------------------------
	// position word
	// ----------------------------------------------------------------
	localparam int unsigned POS_W = 16;

	typedef enum logic [1:0] {
		TPC_RES_10 = 2'b00,
		TPC_RES_12 = 2'b01,
		TPC_RES_14 = 2'b10,
		TPC_RES_16 = 2'b11
	} tpc_res_t;

	localparam logic [POS_W-1:0] MASK_10 = 16'hffc0;
	localparam logic [POS_W-1:0] MASK_12 = 16'hfff0;
	localparam logic [POS_W-1:0] MASK_14 = 16'hfffc;
	localparam logic [POS_W-1:0] MASK_16 = 16'hffff;
	localparam logic [POS_W-1:0] STEP_10 = 16'h0040;
	localparam logic [POS_W-1:0] STEP_12 = 16'h0010;
	localparam logic [POS_W-1:0] STEP_14 = 16'h0004;
	localparam logic [POS_W-1:0] STEP_16 = 16'h0001;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int unsigned    ADDR_W        = 8;
	localparam logic [7:0]     ADDR_CTRL     = 8'h00;
	localparam logic [7:0]     ADDR_POS      = 8'h04;
	localparam logic [7:0]     ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0]     ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0]     ADDR_REVS     = 8'h10;

	localparam int unsigned    CTRL_HOLD_BIT  = 0;
	localparam int unsigned    POS_DIR_BIT    = 16;
	localparam int unsigned    POS_BUSY_BIT   = 17;
	localparam int unsigned    POS_RES_LSB    = 18;
	localparam int unsigned    IRQ_STEP_BIT   = 0;
	localparam int unsigned    IRQ_CARRY_BIT  = 1;
	localparam int unsigned    IRQ_DIR_BIT    = 2;
	localparam int unsigned    IRQ_W          = 3;

	localparam logic [31:0]    RDATA_RST     = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_RST     = 3'h0;
	localparam logic [POS_W-1:0] POS_RST     = 16'h0000;
	localparam logic [4:0]       PIN_RST     = 5'h04;    // hold_n idles high

endpackage

// file: hw/tpc_sync.sv
// two-flop synchroniser for pin inputs
// assumes the inputs are quasi-static or pulses wider than two clocks
`timescale 1ns/1ns
module tpc_sync #(
	parameter int unsigned  W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= RST;
			q      <= RST;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// file: hw/tpc_top.sv
// tracking position counter: output latch, busy, carry and direction, apb registers
// assumes step pins, hold and resolution pins are asynchronous to pclk;
// each step pin rising edge is one lsb of input movement
`timescale 1ns/1ns

// How it works
// R1 - two select pins choose 10, 12, 14 or 16 bit position width
// R2 - outside party should change resolution only while busy is low
// R3 - no convert request; each lsb step moves the counter up or down
// R4 - each single lsb counter change gives one busy pulse
// R5 - one revolution spans 1024, 4096, 16384 or 65536 counts
// R6 - position is plain unsigned binary, no gray coding
// R7 - carry pulse when counter wraps all ones to zero or back
// R8 - direction output settles before its carry pulse appears
// R9 - direction is latched and toggles only on a real one lsb reversal
// R10 - hold never delays or blocks carry or direction
// R11 - while hold is low the output latch stays frozen
// R12 - position is invalid while busy is high; reader waits
// R13 - releasing hold issues one busy pulse refreshing the latch
// R14 - unused low-order data lines read low below 16 bits
// R15 - select pins decode to resolution by a fixed table
// R16 - counter wraps modulo two to the resolution, continuous both ways
module tpc_top (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [tpc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      step_up_in,
	input  wire logic                      step_dn_in,
	input  wire logic                      hold_n,
	input  wire logic                      resolution_select_a,
	input  wire logic                      resolution_select_b,
	output logic      [tpc_pkg::POS_W-1:0] position,
	output logic                           busy,
	output logic                           carry,
	output logic                           dir,
	output logic                           irq
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	logic       up_d_r;
	logic       dn_d_r;
	logic       up_s;
	logic       dn_s;
	logic       hold_n_s;
	tpc_pkg::tpc_res_t res_pin_s;

	tpc_sync #(
		.W   (5),
		.RST (tpc_pkg::PIN_RST)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({resolution_select_b, resolution_select_a, hold_n, step_dn_in, step_up_in}),
		.q       (pins_s)
	);

	assign up_s      = pins_s[0];
	assign dn_s      = pins_s[1];
	assign hold_n_s  = pins_s[2];
	assign res_pin_s = tpc_pkg::tpc_res_t'(pins_s[4:3]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_d_r <= 1'b0;
			dn_d_r <= 1'b0;
		end else begin
			up_d_r <= up_s;
			dn_d_r <= dn_s;
		end
	end

	// ----------------------------------------------------------------
	// resolution select
	// ----------------------------------------------------------------
	tpc_pkg::tpc_res_t         res_r;
	logic [tpc_pkg::POS_W-1:0] mask;
	logic [tpc_pkg::POS_W-1:0] inc;
	logic                      busy_r;

	// a new setting is taken only between busy pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_r <= tpc_pkg::TPC_RES_10;
		end else if (!busy_r) begin
			res_r <= res_pin_s;                                        // [R1] [R2]
		end
	end

	always_comb begin
		unique case (res_r)                                            // [R15]
			tpc_pkg::TPC_RES_10: begin
				mask = tpc_pkg::MASK_10;                               // [R5]
				inc  = tpc_pkg::STEP_10;
			end
			tpc_pkg::TPC_RES_12: begin
				mask = tpc_pkg::MASK_12;
				inc  = tpc_pkg::STEP_12;
			end
			tpc_pkg::TPC_RES_14: begin
				mask = tpc_pkg::MASK_14;
				inc  = tpc_pkg::STEP_14;
			end
			tpc_pkg::TPC_RES_16: begin
				mask = tpc_pkg::MASK_16;
				inc  = tpc_pkg::STEP_16;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	tpc_cnt_if cif ();

	assign cif.step_up = up_s & ~up_d_r;                               // [R3]
	assign cif.step_dn = dn_s & ~dn_d_r;
	assign cif.mask    = mask;
	assign cif.inc     = inc;

	tpc_counter u_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.cif     (cif)
	);

	// ----------------------------------------------------------------
	// hold and busy
	// ----------------------------------------------------------------
	logic                      ctrl_hold_r;
	logic                      hold_act;
	logic                      hold_d_r;
	logic                      hold_rel;
	logic                      busy_trig;
	logic [tpc_pkg::TMR_W-1:0] busy_tmr_r;

	assign hold_act  = ~hold_n_s | ctrl_hold_r;
	assign hold_rel  = hold_d_r & ~hold_act;
	assign busy_trig = cif.stepped | hold_rel;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_d_r <= 1'b0;
		end else begin
			hold_d_r <= hold_act;
		end
	end

	// every step or hold release restarts a fixed-width busy pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r     <= 1'b0;
			busy_tmr_r <= '0;
		end else if (busy_trig) begin
			busy_r     <= 1'b1;                                        // [R4] [R13]
			busy_tmr_r <= tpc_pkg::TMR_W'(tpc_pkg::BUSY_CYC - 1);
		end else if (busy_tmr_r != '0) begin
			busy_tmr_r <= busy_tmr_r - 1'b1;
		end else begin
			busy_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// output latch
	// ----------------------------------------------------------------
	logic [tpc_pkg::POS_W-1:0] pos_r;

	// loaded while busy rises, so data changes only under busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_r <= tpc_pkg::POS_RST;
		end else if (busy_trig && !hold_act) begin                     // [R11] [R12] [R13]
			pos_r <= cif.count & mask;                                 // [R6] [R14]
		end
	end

	// ----------------------------------------------------------------
	// direction and carry
	// ----------------------------------------------------------------
	logic                      dir_r;
	logic                      wrap_d_r;
	logic                      carry_r;
	logic [tpc_pkg::TMR_W-1:0] carry_tmr_r;
	logic                      dir_chg;

	assign dir_chg = dir_r ^ cif.dir;

	// direction follows the counter one cycle before the carry, hold ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_r    <= 1'b0;
			wrap_d_r <= 1'b0;
		end else begin
			dir_r    <= cif.dir;                                       // [R9] [R10]
			wrap_d_r <= cif.wrapped;                                   // [R8]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_r     <= 1'b0;
			carry_tmr_r <= '0;
		end else if (wrap_d_r) begin
			carry_r     <= 1'b1;                                       // [R7] [R10]
			carry_tmr_r <= tpc_pkg::TMR_W'(tpc_pkg::CARRY_CYC - 1);
		end else if (carry_tmr_r != '0) begin
			carry_tmr_r <= carry_tmr_r - 1'b1;
		end else begin
			carry_r <= 1'b0;
		end
	end

	// revolution count kept for software, signed by direction
	logic [15:0] revs_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			revs_r <= 16'h0000;
		end else if (cif.wrapped) begin
			revs_r <= cif.dir ? revs_r - 16'h0001 : revs_r + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	logic                   acc;
	logic                   wr_en;
	logic                   hit;
	logic [31:0]            rd_mux;
	logic [tpc_pkg::IRQ_W-1:0] irq_stat_r;
	logic [tpc_pkg::IRQ_W-1:0] irq_mask_r;
	logic [tpc_pkg::IRQ_W-1:0] irq_evt;

	// answer comes one cycle into the access phase
	assign acc   = psel & penable & ~pready;
	assign wr_en = psel & penable & pready & pwrite & ~pslverr;

	always_comb begin
		hit    = 1'b1;
		rd_mux = tpc_pkg::RDATA_RST;
		unique case (paddr)
			tpc_pkg::ADDR_CTRL: begin
				rd_mux[tpc_pkg::CTRL_HOLD_BIT] = ctrl_hold_r;
			end
			tpc_pkg::ADDR_POS: begin
				rd_mux[tpc_pkg::POS_W-1:0]       = pos_r;
				rd_mux[tpc_pkg::POS_DIR_BIT]     = dir_r;
				rd_mux[tpc_pkg::POS_BUSY_BIT]    = busy_r;
				rd_mux[tpc_pkg::POS_RES_LSB +: 2] = res_r;
			end
			tpc_pkg::ADDR_IRQ_STAT: begin
				rd_mux[tpc_pkg::IRQ_W-1:0] = irq_stat_r;
			end
			tpc_pkg::ADDR_IRQ_MASK: begin
				rd_mux[tpc_pkg::IRQ_W-1:0] = irq_mask_r;
			end
			tpc_pkg::ADDR_REVS: begin
				rd_mux[15:0] = revs_r;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= tpc_pkg::RDATA_RST;
		end else begin
			pready  <= acc;
			pslverr <= acc & ~hit;
			if (acc && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_hold_r <= 1'b0;
			irq_mask_r  <= tpc_pkg::IRQ_RST;
		end else if (wr_en) begin
			if (paddr == tpc_pkg::ADDR_CTRL) begin
				ctrl_hold_r <= pwdata[tpc_pkg::CTRL_HOLD_BIT];
			end
			if (paddr == tpc_pkg::ADDR_IRQ_MASK) begin
				irq_mask_r <= pwdata[tpc_pkg::IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupts: sticky, write one to clear, set wins
	// ----------------------------------------------------------------
	assign irq_evt[tpc_pkg::IRQ_STEP_BIT]  = cif.stepped;
	assign irq_evt[tpc_pkg::IRQ_CARRY_BIT] = wrap_d_r;
	assign irq_evt[tpc_pkg::IRQ_DIR_BIT]   = dir_chg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= tpc_pkg::IRQ_RST;
		end else begin
			if (wr_en && paddr == tpc_pkg::ADDR_IRQ_STAT) begin
				irq_stat_r <= (irq_stat_r & ~pwdata[tpc_pkg::IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat_r <= irq_stat_r | irq_evt;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			position <= tpc_pkg::POS_RST;
			busy     <= 1'b0;
			carry    <= 1'b0;
			dir      <= 1'b0;
		end else begin
			position <= pos_r;                                         // [R6]
			busy     <= busy_r;                                        // [R12]
			carry    <= carry_r;
			dir      <= dir_r;                                         // [R8]
		end
	end
endmodule
